// ### rtl/pip_pkg.sv
// Constants shared by the port integration block and its helpers.
// Assumes an 8-bit register port with the offsets below.
package pip_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_PORT_E_ASSIGN = 8'h0A;
  localparam logic [7:0] OFS_MODE = 8'h0B;
  localparam logic [7:0] OFS_EBI_CTL = 8'h0E;
  localparam logic [7:0] OFS_PM_DATA = 8'h10;
  localparam logic [7:0] OFS_PM_IN = 8'h11;
  localparam logic [7:0] OFS_PM_DIR = 8'h12;
  localparam logic [7:0] OFS_MISC = 8'h13;
  localparam logic [7:0] OFS_PM_PULL_EN = 8'h14;
  localparam logic [7:0] OFS_PM_PULL_POL = 8'h15;
  localparam logic [7:0] OFS_PM_OPEN_DRAIN = 8'h16;
  localparam logic [7:0] OFS_PJ_DATA = 8'h28;
  localparam logic [7:0] OFS_PJ_IN = 8'h29;
  localparam logic [7:0] OFS_PJ_DIR = 8'h2A;
  localparam logic [7:0] OFS_PJ_DRIVE = 8'h2B;
  localparam logic [7:0] OFS_PAD_DATA = 8'h30;
  localparam logic [7:0] OFS_PAD_IN = 8'h31;
  localparam logic [7:0] OFS_PAD_DIR = 8'h32;
  // Field positions
  localparam int BIT_CLK_OUT_DIS = 4;
  localparam int BIT_LOW_STROBE_EN = 3;
  localparam int BIT_MODE_B = 7;
  localparam int BIT_MODE_A = 6;
  localparam int BIT_INT_VIS = 3;
  localparam int BIT_STRETCH_EN = 0;
  localparam int BIT_EXT_STR_LO = 2;
  // Implemented bits per port
  localparam logic [7:0] MASK_PM = 8'h3F;
  localparam logic [7:0] MASK_PJ = 8'hC0;
  localparam int PM_W = 6;
  localparam int PJ_W = 2;
  localparam int PJ_LO = 6;
  // Reset values
  localparam logic RST_STRETCH_EN = 1'b1;
  localparam logic [1:0] RST_EXT_STR = 2'h3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Bus clock stretch: hold counter width; each stretch step adds two core cycles
  localparam int HOLD_W = 3;
endpackage

// ### rtl/pip_bus_clock_out_if.sv
// Control and status between the port top and the bus clock generator.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface pip_bus_clock_out_if;
  logic stretch_en;
  logic [1:0] stretch;
  logic ext_access;
  logic stop;
  logic clk_q;
  modport ctrl (output stretch_en, output stretch, output ext_access,
    output stop, input clk_q);
  modport gen (input stretch_en, input stretch, input ext_access,
    input stop, output clk_q);
endinterface

// ### rtl/pip_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module pip_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

// ### rtl/pip_bus_clock_out.sv
// Bus clock generator: half the reference rate, stretched high phase.
// Assumes stop and access requests come from logic on clk_i.
`timescale 1ns/1ps
module pip_bus_clock_out (
  input wire logic clk_i,
  input wire logic arst_n_i,
  pip_bus_clock_out_if.gen bus
);
  logic clk_q;
  logic next_clk_q;
  logic pend;
  logic next_pend;
  logic [pip_pkg::HOLD_W-1:0] hold;
  logic [pip_pkg::HOLD_W-1:0] next_hold;

  always_comb
  begin
    next_clk_q = clk_q;
    next_pend = pend;
    next_hold = hold;
    if (bus.ext_access && bus.stretch_en)
    begin
      next_pend = 1'b1;
    end
    if (!bus.stop)
    begin
      if (hold != '0)
      begin
        next_hold = hold - 3'h1;
      end
      else
      begin
        next_clk_q = ~clk_q;
        if (!clk_q && next_pend)
        begin
          next_hold = {bus.stretch, 1'b0};
          next_pend = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clk_q <= 1'b0;
      pend <= 1'b0;
      hold <= '0;
    end
    else
    begin
      clk_q <= next_clk_q;
      pend <= next_pend;
      hold <= next_hold;
    end
  end

  assign bus.clk_q = clk_q;

  a_bus_clock_out_halt_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    bus.stop |=> $stable(clk_q))
    else $error("bus clock moved during stop");

  a_bus_clock_out_half_rate: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (!bus.stop && hold == '0) |=> (clk_q != $past(clk_q)))
    else $error("bus clock failed to toggle");

  a_bus_clock_out_stretch_hold: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (!bus.stop && hold != '0) |=> $stable(clk_q))
    else $error("bus clock moved while stretched");
endmodule

// ### rtl/pip_top.sv
// Port integration block: mode straps, bus clock pin, low-byte strobe,
// port M, J and AD configuration and readback.
// Assumes a single-cycle register port on REF_CLK_I and raw pin inputs.
//
// Contract
// - Upper mode pin is caught into mode bit B at reset release; its pull-down acts during reset and until the strap is caught.
// - Lower mode pin is caught into mode bit A at reset release; it is otherwise a plain pin.
// - After reset the bus clock pin toggles at half the reference rate.
// - In expanded modes the bus clock pin starts as clock output with stretch, steered by disable and stretch bits; the visibility bit is only read back.
// - Stop mode halts the bus clock pin; registers and synchronisers keep running on the reference clock.
// - Slow external accesses stretch the bus clock by the external stretch field.
// - Out of reset the low-byte strobe pin is an input with pull-up.
// - No low-byte strobe is driven until the strobe enable bit is set.
// - Port M polarity picks pull-up for input or wired-or output, pull-down only for input, when pull enabled.
// - A port M open-drain bit lets the output drive only low; no effect on inputs.
// - Port J direction bits 7 and 6 make the pin an input at 0 and output at 1.
// - Port J readback may lag a direction change by up to three cycles due to the output flop and the synchroniser.
// - Port J reduced drive applies only while the pin is an output.
// - Port AD data reads the latch for output bits and the pin for others.
// - Port AD input register always reads the pins and ignores writes.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module pip_top (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RD_DATA_O,
  input wire logic STOP_I,
  input wire logic EXT_ACCESS_I,
  input wire logic LOW_WR_N_I,
  input wire logic [1:0] MODE_PIN_I,
  output logic MODE_PD_O,
  output logic MODE_BIT_B_O,
  output logic MODE_BIT_A_O,
  output logic BUS_CLK_O,
  output logic BUS_CLK_OE_O,
  output logic LOW_BYTE_STROBE_N_O,
  output logic LOW_BYTE_STROBE_OE_O,
  output logic LOW_BYTE_STROBE_PU_O,
  input wire logic [5:0] PM_PIN_I,
  output logic [5:0] PM_OUT_O,
  output logic [5:0] PM_OE_O,
  output logic [5:0] PM_PU_O,
  output logic [5:0] PM_PD_O,
  input wire logic [1:0] PJ_PIN_I,
  output logic [1:0] PJ_OUT_O,
  output logic [1:0] PJ_OE_O,
  output logic [1:0] PJ_RDRV_O,
  input wire logic [7:0] PAD_PIN_I,
  output logic [7:0] PAD_OUT_O,
  output logic [7:0] PAD_OE_O
);
  localparam int SYNC_W = 18;

  logic [SYNC_W-1:0] sync_q;
  logic [7:0] pad_sync;
  logic [5:0] pm_sync;
  logic [1:0] pj_sync;
  logic [1:0] mode_sync;

  // Configuration state
  logic clk_out_dis, next_clk_out_dis;
  logic low_strobe_en, next_low_strobe_en;
  logic int_vis, next_int_vis;
  logic stretch_en, next_stretch_en;
  logic [1:0] ext_str, next_ext_str;
  logic [5:0] pm_data, next_pm_data;
  logic [5:0] pm_dir, next_pm_dir;
  logic [5:0] pm_pull_en, next_pm_pull_en;
  logic [5:0] pm_pol, next_pm_pol;
  logic [5:0] pm_od, next_pm_od;
  logic [1:0] pj_data, next_pj_data;
  logic [1:0] pj_dir, next_pj_dir;
  logic [1:0] pj_drv, next_pj_drv;
  logic [7:0] pad_data, next_pad_data;
  logic [7:0] pad_dir, next_pad_dir;
  logic [7:0] next_rd_data;

  // Mode strap state
  logic captured, next_captured;
  // Synchroniser fill tracker, so the strap is taken from a settled value
  logic [1:0] warm, next_warm;
  logic mode_b, next_mode_b;
  logic mode_a, next_mode_a;
  logic expanded;

  pip_bus_clock_out_if ebus ();

  pip_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .d_i({PAD_PIN_I, PM_PIN_I, PJ_PIN_I, MODE_PIN_I}),
    .q_o(sync_q)
  );

  assign pad_sync = sync_q[17:10];
  assign pm_sync = sync_q[9:4];
  assign pj_sync = sync_q[3:2];
  assign mode_sync = sync_q[1:0];
  assign expanded = mode_a;

  assign ebus.stretch_en = stretch_en;
  assign ebus.stretch = ext_str;
  assign ebus.ext_access = EXT_ACCESS_I && expanded;
  assign ebus.stop = STOP_I;

  pip_bus_clock_out u_bus_clock_out (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .bus(ebus)
  );

  // Strap capture once, just after reset release
  always_comb
  begin
    next_warm = {warm[0], 1'b1};
    next_captured = captured | warm[1];
    next_mode_b = mode_b;
    next_mode_a = mode_a;
    if (!captured && warm[1])
    begin
      next_mode_b = mode_sync[1];
      next_mode_a = mode_sync[0];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      captured <= 1'b0;
      warm <= '0;
      mode_b <= 1'b0;
      mode_a <= 1'b0;
    end
    else
    begin
      captured <= next_captured;
      warm <= next_warm;
      mode_b <= next_mode_b;
      mode_a <= next_mode_a;
    end
  end

  // Register writes and read mux
  always_comb
  begin
    next_clk_out_dis = clk_out_dis;
    next_low_strobe_en = low_strobe_en;
    next_int_vis = int_vis;
    next_stretch_en = stretch_en;
    next_ext_str = ext_str;
    next_pm_data = pm_data;
    next_pm_dir = pm_dir;
    next_pm_pull_en = pm_pull_en;
    next_pm_pol = pm_pol;
    next_pm_od = pm_od;
    next_pj_data = pj_data;
    next_pj_dir = pj_dir;
    next_pj_drv = pj_drv;
    next_pad_data = pad_data;
    next_pad_dir = pad_dir;
    next_rd_data = pip_pkg::RST_ZERO;
    if (WR_I)
    begin
      case (ADDR_I)
        pip_pkg::OFS_PORT_E_ASSIGN:
        begin
          next_clk_out_dis = WR_DATA_I[pip_pkg::BIT_CLK_OUT_DIS];
          next_low_strobe_en = WR_DATA_I[pip_pkg::BIT_LOW_STROBE_EN];
        end
        pip_pkg::OFS_MODE: next_int_vis = WR_DATA_I[pip_pkg::BIT_INT_VIS];
        pip_pkg::OFS_EBI_CTL:
          next_stretch_en = WR_DATA_I[pip_pkg::BIT_STRETCH_EN];
        pip_pkg::OFS_MISC:
          next_ext_str = WR_DATA_I[pip_pkg::BIT_EXT_STR_LO+:2];
        pip_pkg::OFS_PM_DATA: next_pm_data = WR_DATA_I[pip_pkg::PM_W-1:0];
        pip_pkg::OFS_PM_DIR: next_pm_dir = WR_DATA_I[pip_pkg::PM_W-1:0];
        pip_pkg::OFS_PM_PULL_EN:
          next_pm_pull_en = WR_DATA_I[pip_pkg::PM_W-1:0];
        pip_pkg::OFS_PM_PULL_POL:
          next_pm_pol = WR_DATA_I[pip_pkg::PM_W-1:0];
        pip_pkg::OFS_PM_OPEN_DRAIN:
          next_pm_od = WR_DATA_I[pip_pkg::PM_W-1:0];
        pip_pkg::OFS_PJ_DATA:
          next_pj_data = WR_DATA_I[pip_pkg::PJ_LO+:pip_pkg::PJ_W];
        pip_pkg::OFS_PJ_DIR:
          next_pj_dir = WR_DATA_I[pip_pkg::PJ_LO+:pip_pkg::PJ_W];
        pip_pkg::OFS_PJ_DRIVE:
          next_pj_drv = WR_DATA_I[pip_pkg::PJ_LO+:pip_pkg::PJ_W];
        pip_pkg::OFS_PAD_DATA: next_pad_data = WR_DATA_I;
        pip_pkg::OFS_PAD_DIR: next_pad_dir = WR_DATA_I;
        default: next_rd_data = pip_pkg::RST_ZERO; // Input regs ignore
      endcase
    end
    if (RD_I)
    begin
      case (ADDR_I)
        pip_pkg::OFS_PORT_E_ASSIGN:
        begin
          next_rd_data[pip_pkg::BIT_CLK_OUT_DIS] = clk_out_dis;
          next_rd_data[pip_pkg::BIT_LOW_STROBE_EN] = low_strobe_en;
        end
        pip_pkg::OFS_MODE:
        begin
          next_rd_data[pip_pkg::BIT_MODE_B] = mode_b;
          next_rd_data[pip_pkg::BIT_MODE_A] = mode_a;
          next_rd_data[pip_pkg::BIT_INT_VIS] = int_vis;
        end
        pip_pkg::OFS_EBI_CTL:
          next_rd_data[pip_pkg::BIT_STRETCH_EN] = stretch_en;
        pip_pkg::OFS_MISC:
          next_rd_data[pip_pkg::BIT_EXT_STR_LO+:2] = ext_str;
        pip_pkg::OFS_PM_DATA:
          next_rd_data[pip_pkg::PM_W-1:0] =
            (pm_dir & pm_data) | (~pm_dir & pm_sync);
        pip_pkg::OFS_PM_IN: next_rd_data[pip_pkg::PM_W-1:0] = pm_sync;
        pip_pkg::OFS_PM_DIR: next_rd_data[pip_pkg::PM_W-1:0] = pm_dir;
        pip_pkg::OFS_PM_PULL_EN:
          next_rd_data[pip_pkg::PM_W-1:0] = pm_pull_en;
        pip_pkg::OFS_PM_PULL_POL: next_rd_data[pip_pkg::PM_W-1:0] = pm_pol;
        pip_pkg::OFS_PM_OPEN_DRAIN: next_rd_data[pip_pkg::PM_W-1:0] = pm_od;
        pip_pkg::OFS_PJ_DATA:
          next_rd_data[pip_pkg::PJ_LO+:pip_pkg::PJ_W] =
            (pj_dir & pj_data) | (~pj_dir & pj_sync);
        pip_pkg::OFS_PJ_IN:
          next_rd_data[pip_pkg::PJ_LO+:pip_pkg::PJ_W] = pj_sync;
        pip_pkg::OFS_PJ_DIR:
          next_rd_data[pip_pkg::PJ_LO+:pip_pkg::PJ_W] = pj_dir;
        pip_pkg::OFS_PJ_DRIVE:
          next_rd_data[pip_pkg::PJ_LO+:pip_pkg::PJ_W] = pj_drv;
        pip_pkg::OFS_PAD_DATA:
          next_rd_data = (pad_dir & pad_data) | (~pad_dir & pad_sync);
        pip_pkg::OFS_PAD_IN: next_rd_data = pad_sync;
        pip_pkg::OFS_PAD_DIR: next_rd_data = pad_dir;
        default: next_rd_data = pip_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      clk_out_dis <= 1'b0;
      low_strobe_en <= 1'b0;
      int_vis <= 1'b0;
      stretch_en <= pip_pkg::RST_STRETCH_EN;
      ext_str <= pip_pkg::RST_EXT_STR;
      pm_data <= '0;
      pm_dir <= '0;
      pm_pull_en <= '0;
      pm_pol <= '0;
      pm_od <= '0;
      pj_data <= '0;
      pj_dir <= '0;
      pj_drv <= '0;
      pad_data <= '0;
      pad_dir <= '0;
      RD_DATA_O <= pip_pkg::RST_ZERO;
    end
    else
    begin
      clk_out_dis <= next_clk_out_dis;
      low_strobe_en <= next_low_strobe_en;
      int_vis <= next_int_vis;
      stretch_en <= next_stretch_en;
      ext_str <= next_ext_str;
      pm_data <= next_pm_data;
      pm_dir <= next_pm_dir;
      pm_pull_en <= next_pm_pull_en;
      pm_pol <= next_pm_pol;
      pm_od <= next_pm_od;
      pj_data <= next_pj_data;
      pj_dir <= next_pj_dir;
      pj_drv <= next_pj_drv;
      pad_data <= next_pad_data;
      pad_dir <= next_pad_dir;
      RD_DATA_O <= next_rd_data;
    end
  end

  // Pin drivers, registered so every output leaves a flop
  logic next_mode_pd, next_clk_oe, next_low_byte_strobe_n, next_low_byte_strobe_oe;
  logic next_low_byte_strobe_pu;
  logic [5:0] next_pm_oe, next_pm_pu, next_pm_pd;
  logic [1:0] next_pj_oe, next_pj_rdrv;

  always_comb
  begin
    next_mode_pd = !captured;
    next_clk_oe = expanded && !clk_out_dis;
    next_low_byte_strobe_oe = expanded && low_strobe_en;
    next_low_byte_strobe_n = LOW_WR_N_I || !next_low_byte_strobe_oe;
    next_low_byte_strobe_pu = !next_low_byte_strobe_oe;
    next_pm_oe = pm_dir & ~(pm_od & pm_data);
    next_pm_pu = pm_pull_en & ~pm_pol & (~pm_dir | pm_od);
    next_pm_pd = pm_pull_en & pm_pol & ~pm_dir;
    next_pj_oe = pj_dir;
    next_pj_rdrv = pj_drv & pj_dir;
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      MODE_PD_O <= 1'b1;
      MODE_BIT_B_O <= 1'b0;
      MODE_BIT_A_O <= 1'b0;
      BUS_CLK_OE_O <= 1'b0;
      LOW_BYTE_STROBE_N_O <= 1'b1;
      LOW_BYTE_STROBE_OE_O <= 1'b0;
      LOW_BYTE_STROBE_PU_O <= 1'b1;
      PM_OUT_O <= '0;
      PM_OE_O <= '0;
      PM_PU_O <= '0;
      PM_PD_O <= '0;
      PJ_OUT_O <= '0;
      PJ_OE_O <= '0;
      PJ_RDRV_O <= '0;
      PAD_OUT_O <= '0;
      PAD_OE_O <= '0;
    end
    else
    begin
      MODE_PD_O <= next_mode_pd;
      MODE_BIT_B_O <= mode_b;
      MODE_BIT_A_O <= mode_a;
      BUS_CLK_OE_O <= next_clk_oe;
      LOW_BYTE_STROBE_N_O <= next_low_byte_strobe_n;
      LOW_BYTE_STROBE_OE_O <= next_low_byte_strobe_oe;
      LOW_BYTE_STROBE_PU_O <= next_low_byte_strobe_pu;
      PM_OUT_O <= pm_data;
      PM_OE_O <= next_pm_oe;
      PM_PU_O <= next_pm_pu;
      PM_PD_O <= next_pm_pd;
      PJ_OUT_O <= pj_data;
      PJ_OE_O <= next_pj_oe;
      PJ_RDRV_O <= next_pj_rdrv;
      PAD_OUT_O <= pad_data;
      PAD_OE_O <= pad_dir;
    end
  end

  assign BUS_CLK_O = ebus.clk_q;

  a_strap_b_caught: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    $rose(captured) |-> (mode_b == $past(mode_sync[1])))
    else $error("mode bit B not caught at release");

  a_strap_a_held: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    ($past(captured) && captured) |-> $stable(mode_a))
    else $error("mode bit A changed after capture");

  a_strap_pd_off: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    captured |=> !MODE_PD_O)
    else $error("mode pull-down active after reset");

  a_low_byte_strobe_gated: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    !low_strobe_en |=> (!LOW_BYTE_STROBE_OE_O && LOW_BYTE_STROBE_N_O && LOW_BYTE_STROBE_PU_O))
    else $error("low strobe driven while disabled");

  a_pm_open_drain: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    ##1 ((PM_OE_O & PM_OUT_O & $past(pm_od)) == '0))
    else $error("open-drain pin driven high");

  a_pm_pulldown_in: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    ##1 ((PM_PD_O & ($past(pm_dir) | ~$past(pm_pol))) == '0))
    else $error("pull-down on output or pull-up bit");

  a_pj_rdrv_out: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    ##1 ((PJ_RDRV_O & ~$past(pj_dir)) == '0))
    else $error("reduced drive on input pin");

  a_pad_data_read: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    (RD_I && ADDR_I == pip_pkg::OFS_PAD_DATA) |=>
      (RD_DATA_O == (($past(pad_dir) & $past(pad_data)) |
      (~$past(pad_dir) & $past(pad_sync)))))
    else $error("port AD data read wrong");

  a_pad_input_read: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    (RD_I && ADDR_I == pip_pkg::OFS_PAD_IN) |=>
      (RD_DATA_O == $past(pad_sync)))
    else $error("port AD input read wrong");
endmodule

// ### dv/pip_pin_model.sv
// Pin-side model: straps, pulls and external drivers on ports M, J, AD.
// Assumes the testbench sets the external levels off the sampling edge.
`timescale 1ns/1ps
module pip_pin_model (
  input wire logic clk_i,
  input wire logic [1:0] strap_i,
  output logic [1:0] mode_pin_o,
  input wire logic [5:0] pm_out_i,
  input wire logic [5:0] pm_oe_i,
  input wire logic [5:0] pm_pu_i,
  input wire logic [5:0] pm_pd_i,
  output logic [5:0] pm_pin_o,
  input wire logic [1:0] pj_out_i,
  input wire logic [1:0] pj_oe_i,
  input wire logic [1:0] pj_ext_i,
  output logic [1:0] pj_pin_o,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pad_ext_i,
  input wire logic [7:0] pad_short_i,
  output logic [7:0] pad_pin_o
);
  logic [5:0] float_q = 6'h15;
  // Undriven, unpulled pins wander every cycle
  always_ff @(posedge clk_i)
  begin
    float_q <= ~float_q;
  end
  assign mode_pin_o = strap_i;
  // Driven bits win, then pull-up, then pull-down
  assign pm_pin_o = (pm_oe_i & pm_out_i) | (~pm_oe_i & pm_pu_i)
    | (~pm_oe_i & ~pm_pu_i & ~pm_pd_i & float_q);
  assign pj_pin_o = (pj_oe_i & pj_out_i) | (~pj_oe_i & pj_ext_i);
  // A shorted pin reads low whatever is driven
  assign pad_pin_o = ((pad_oe_i & pad_out_i) | (~pad_oe_i & pad_ext_i))
    & ~pad_short_i;
endmodule

// ### dv/tb_pip_top.sv
// Self-checking bench for the port integration block.
// Assumes one 50 MHz clock and the single-cycle register port.
`timescale 1ns/1ps
module tb_pip_top;
  logic clk = 1'b0, arst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic stop = 1'b0, ext_acc = 1'b0, low_wr_n = 1'b1;
  logic [1:0] mode_pin, pj_pin, pj_out, pj_oe, pj_rdrv;
  logic [1:0] pj_ext = 2'h2;
  logic mode_pd, mode_b, mode_a, bclk, bclk_oe, ls_n, ls_oe, ls_pu;
  logic [5:0] pm_pin, pm_out, pm_oe, pm_pu, pm_pd;
  logic [7:0] pad_pin, pad_out, pad_oe;
  logic [7:0] pad_ext = 8'h3C, pad_short = 8'h00;
  int bad_count = 0, tests_run = 0, n, f, i;
  logic [7:0] ta [3] = '{8'h15, 8'h16, 8'h2B};
  logic [7:0] tm [3] = '{8'h3F, 8'h3F, 8'hC0};
  pip_top u_pip_top (.REF_CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr),
    .WR_DATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RD_DATA_O(rdata),
    .STOP_I(stop), .EXT_ACCESS_I(ext_acc), .LOW_WR_N_I(low_wr_n),
    .MODE_PIN_I(mode_pin), .MODE_PD_O(mode_pd), .MODE_BIT_B_O(mode_b),
    .MODE_BIT_A_O(mode_a), .BUS_CLK_O(bclk), .BUS_CLK_OE_O(bclk_oe),
    .LOW_BYTE_STROBE_N_O(ls_n), .LOW_BYTE_STROBE_OE_O(ls_oe), .LOW_BYTE_STROBE_PU_O(ls_pu),
    .PM_PIN_I(pm_pin), .PM_OUT_O(pm_out), .PM_OE_O(pm_oe), .PM_PU_O(pm_pu),
    .PM_PD_O(pm_pd), .PJ_PIN_I(pj_pin), .PJ_OUT_O(pj_out), .PJ_OE_O(pj_oe),
    .PJ_RDRV_O(pj_rdrv), .PAD_PIN_I(pad_pin), .PAD_OUT_O(pad_out),
    .PAD_OE_O(pad_oe));
  pip_pin_model u_pip_pin_model (.clk_i(clk), .strap_i(2'h1),
    .mode_pin_o(mode_pin), .pm_out_i(pm_out), .pm_oe_i(pm_oe),
    .pm_pu_i(pm_pu), .pm_pd_i(pm_pd), .pm_pin_o(pm_pin), .pj_out_i(pj_out),
    .pj_oe_i(pj_oe), .pj_ext_i(pj_ext), .pj_pin_o(pj_pin),
    .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pad_ext_i(pad_ext),
    .pad_short_i(pad_short), .pad_pin_o(pad_pin));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk("read data", e, rdata);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  // High phase length of the next bus clock pulse, in reference cycles
  task automatic hi_len(output int m);
    int k;
    m = 0;
    @(negedge clk);
    for (k = 0; k < 40 && bclk !== 1'b1; k++) @(negedge clk);
    while (m < 40 && bclk === 1'b1)
    begin
      m++;
      @(negedge clk);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (3) @(negedge clk);
    chk("mode pull-down", 8'h01, {7'h0, mode_pd});
    chk("strobe pull-up", 8'h01, {7'h0, ls_pu});
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(negedge clk);
    chk("mode pull-down", 8'h00, {7'h0, mode_pd});
    chk("mode bits", 8'h01, {6'h0, mode_b, mode_a});
    rc(pip_pkg::OFS_MODE, 8'h40);
    chk("strobe pin", 8'h01, {6'h0, ls_oe, ls_pu});
    chk("bus clock enable", 8'h01, {7'h0, bclk_oe});
    for (i = 0; i < 4; i++)
    begin
      n = bclk;
      @(negedge clk);
      chk("bus clock toggle", {7'h0, ~n[0]}, {7'h0, bclk});
    end
    @(posedge clk);
    stop <= 1'b1;
    @(negedge clk);
    n = bclk;
    repeat (5) @(negedge clk);
    chk("bus clock stop", {7'h0, n[0]}, {7'h0, bclk});
    stop <= 1'b0;
    for (f = 0; f < 4; f++)
    begin
      wr(pip_pkg::OFS_MISC, 8'(f << 2));
      @(posedge clk);
      ext_acc <= 1'b1;
      @(posedge clk);
      ext_acc <= 1'b0;
      hi_len(n);
      chk("stretch high", 8'(1 + 2 * f), 8'(n));
    end
    wr(pip_pkg::OFS_PORT_E_ASSIGN, 8'h10);
    settle;
    chk("bus clock disable", 8'h00, {7'h0, bclk_oe});
    low_wr_n <= 1'b0;
    wr(pip_pkg::OFS_PORT_E_ASSIGN, 8'h08);
    settle;
    chk("strobe enable", 8'h12, {3'h0, bclk_oe, 2'h0, ls_oe, ls_n});
    low_wr_n <= 1'b1;
    settle;
    chk("strobe follows", 8'h01, {7'h0, ls_n});
    wr(pip_pkg::OFS_MODE, 8'h08);
    rc(pip_pkg::OFS_MODE, 8'h48);
    for (i = 0; i < 3; i++)
    begin
      rc(ta[i], 8'h00);
      wr(ta[i], 8'hFF);
      rc(ta[i], tm[i]);
    end
    rc(8'h7F, 8'h00);
    wr(pip_pkg::OFS_PM_PULL_EN, 8'h3F);
    wr(pip_pkg::OFS_PM_PULL_POL, 8'h0F);
    wr(pip_pkg::OFS_PM_DIR, 8'h00);
    settle;
    chk("pm pulls", 8'hCF, {pm_pu[5:4], pm_pd});
    chk("pm inputs undriven", 8'h00, {2'h0, pm_oe});
    rc(pip_pkg::OFS_PM_IN, 8'h30);
    wr(pip_pkg::OFS_PM_DATA, 8'h2A);
    wr(pip_pkg::OFS_PM_DIR, 8'h3F);
    settle;
    chk("pm open drain oe", 8'h15, {2'h0, pm_oe});
    chk("pm open drain hi", 8'h00, {2'h0, pm_oe & pm_out});
    chk("pm wired-or pulls", 8'h30, {pm_pu, 2'h0} >> 2 | {2'h0, pm_pd});
    wr(pip_pkg::OFS_PM_OPEN_DRAIN, 8'h00);
    settle;
    chk("pm push-pull", 8'h3F, {2'h0, pm_oe});
    chk("pm push-pull out", 8'h2A, {2'h0, pm_out});
    chk("pm output pulls", 8'h00, {2'h0, pm_pu | pm_pd});
    wr(pip_pkg::OFS_PJ_DIR, 8'h00);
    settle;
    chk("pj input", 8'h00, {4'h0, pj_oe, pj_rdrv});
    rc(pip_pkg::OFS_PJ_DATA, 8'h80);
    rc(pip_pkg::OFS_PJ_IN, 8'h80);
    wr(pip_pkg::OFS_PJ_DATA, 8'h40);
    wr(pip_pkg::OFS_PJ_DIR, 8'hC0);
    settle;
    chk("pj output", 8'h3D, {2'h0, pj_oe, pj_rdrv, pj_out});
    rc(pip_pkg::OFS_PJ_DATA, 8'h40);
    rc(pip_pkg::OFS_PJ_IN, 8'h40);
    pad_short <= 8'h80;
    wr(pip_pkg::OFS_PAD_DATA, 8'hA5);
    wr(pip_pkg::OFS_PAD_DIR, 8'hF0);
    settle;
    chk("pad outputs", 8'hA0, pad_oe & pad_out);
    rc(pip_pkg::OFS_PAD_DATA, 8'hAC);
    wr(pip_pkg::OFS_PAD_IN, 8'hFF);
    rc(pip_pkg::OFS_PAD_IN, 8'h2C);
    fork
      rc(pip_pkg::OFS_PAD_IN, 8'h2C);
      begin
        @(posedge clk);
        pad_ext <= 8'h03;
      end
    join
    settle;
    rc(pip_pkg::OFS_PAD_IN, 8'h23);
    rc(pip_pkg::OFS_PAD_DATA, 8'hA3);
    finish_test;
  end
endmodule
